// [src/hsdh_pkg.sv]
// Package: constants and state type for the device hiding control
`default_nettype none
package hsdh_pkg;
  // Synchroniser depth for pin inputs
  localparam int unsigned SYNC_STAGES = 2;
  // Number of pin levels that cross into the clock domain
  localparam int unsigned PIN_COUNT = 2;
  // Bit positions of the pin levels in the synchroniser bundle
  localparam int unsigned PIN_RESET_BIT = 0;
  localparam int unsigned PIN_HANDLE_BIT = 1;
  // Reset values of the synchroniser flops: reset held, handle locked
  localparam logic [PIN_COUNT-1:0] PIN_RESET_VAL = 2'h0;
  // Handle switch level that means the ejector handle is unlocked
  localparam logic HANDLE_UNLOCKED = 1'h1;
  // Primary reset level that means reset is inactive
  localparam logic RESET_INACTIVE = 1'h1;

  typedef enum logic [1:0] {
    HSDH_WAIT_RELEASE = 2'h0,
    HSDH_PENDING = 2'h1,
    HSDH_HIDDEN = 2'h2,
    HSDH_NORMAL = 2'h3
  } hsdh_state_t;
endpackage
`default_nettype wire

// [src/hsdh_pin_if.sv]
// Interface: raw pin levels in, synchronised levels out
`default_nettype none
interface hsdh_pin_if;
  logic [hsdh_pkg::PIN_COUNT-1:0] raw;
  logic [hsdh_pkg::PIN_COUNT-1:0] synced;
  modport sync_side (input raw, output synced);
  modport ctrl_side (output raw, input synced);
endinterface
`default_nettype wire

// [src/hsdh_sync.sv]
// Module: multi-stage synchroniser for asynchronous pin levels
`default_nettype none
module hsdh_sync #(
  parameter int unsigned WIDTH = hsdh_pkg::PIN_COUNT,
  parameter int unsigned STAGES = hsdh_pkg::SYNC_STAGES,
  parameter logic [WIDTH-1:0] RESET_VAL = hsdh_pkg::PIN_RESET_VAL
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Pin bundle
  hsdh_pin_if.sync_side pins
);
  logic [WIDTH-1:0] stage_q [STAGES];

  // The first stage feeds only the next stage, never any logic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= RESET_VAL;
      end
    end else if (clk_en) begin
      stage_q[0] <= pins.raw;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign pins.synced = stage_q[STAGES-1];
endmodule
`default_nettype wire

// [src/hsdh_hide_ctrl.sv]
// Module: hot-swap device hiding control on the primary bus clock
`default_nettype none
module hsdh_hide_ctrl (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Pins
  input wire logic primary_reset_in_n,
  input wire logic general_pin_three,
  // Target transaction status from the bridge core
  input wire logic txn_active,
  input wire logic txn_cfg,
  // Controls back to the bridge core
  output logic claim_en,
  output logic tgt_disconnect,
  output logic early_finish,
  output logic master_inhibit,
  output logic io_inhibit,
  output logic irq_inhibit,
  // Status
  output logic hidden,
  output logic quiesced
);
  hsdh_pin_if pin_bus ();

  logic rst_released;
  logic handle_unlocked;
  hsdh_pkg::hsdh_state_t state_q;
  hsdh_pkg::hsdh_state_t state_d;
  logic hidden_q;
  logic disc_q;
  logic quiesce_q;

  assign pin_bus.raw[hsdh_pkg::PIN_RESET_BIT] = primary_reset_in_n;
  assign pin_bus.raw[hsdh_pkg::PIN_HANDLE_BIT] = general_pin_three;

  // Both pins are asynchronous to the bus clock
  hsdh_sync #(
    .WIDTH(hsdh_pkg::PIN_COUNT),
    .STAGES(hsdh_pkg::SYNC_STAGES),
    .RESET_VAL(hsdh_pkg::PIN_RESET_VAL)
  ) u_sync (
    .clk(clk),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .pins(pin_bus.sync_side)
  );

  assign rst_released = pin_bus.synced[hsdh_pkg::PIN_RESET_BIT] == hsdh_pkg::RESET_INACTIVE;
  // Handle is assumed debounced outside; a tied-low pin keeps hiding off
  assign handle_unlocked =
    pin_bus.synced[hsdh_pkg::PIN_HANDLE_BIT] == hsdh_pkg::HANDLE_UNLOCKED;

  // Hiding sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      hsdh_pkg::HSDH_WAIT_RELEASE: begin
        // Decided once per block reset, at the first primary reset release seen after the synchroniser delay
        if (rst_released) begin
          if (handle_unlocked) begin
            state_d = hsdh_pkg::HSDH_PENDING;
          end else begin
            state_d = hsdh_pkg::HSDH_NORMAL;
          end
        end
      end
      hsdh_pkg::HSDH_PENDING: begin
        // Relock before the boundary cancels hiding before it is entered
        if (!handle_unlocked) begin
          state_d = hsdh_pkg::HSDH_NORMAL;
        end else if (!txn_active) begin
          // Boundary reached: the current transaction is over
          state_d = hsdh_pkg::HSDH_HIDDEN;
        end
      end
      hsdh_pkg::HSDH_HIDDEN: begin
        if (!handle_unlocked) begin
          state_d = hsdh_pkg::HSDH_NORMAL;
        end
      end
      hsdh_pkg::HSDH_NORMAL: begin
        state_d = hsdh_pkg::HSDH_NORMAL;
      end
    endcase
  end

  // A later unlock in normal operation is extraction signalling, not a new hide
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= hsdh_pkg::HSDH_WAIT_RELEASE;
    end else if (clk_en) begin
      state_q <= state_d;
    end
  end

  // Hidden flag is set only when no transaction is in flight; a relock clears it on any cycle with the clock enabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hidden_q <= 1'h0;
    end else if (clk_en) begin
      hidden_q <= state_d == hsdh_pkg::HSDH_HIDDEN;
    end
  end

  // Quiesce covers both the pending and hidden phases
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      quiesce_q <= 1'h0;
    end else if (clk_en) begin
      quiesce_q <= state_d == hsdh_pkg::HSDH_PENDING || state_d == hsdh_pkg::HSDH_HIDDEN;
    end
  end

  // Disconnect held until the configuration transaction completes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      disc_q <= 1'h0;
    end else if (clk_en) begin
      disc_q <= state_d == hsdh_pkg::HSDH_PENDING && txn_active && txn_cfg;
    end
  end

  // Claims are refused from the first pending cycle, so an idle bus is shut at once
  assign claim_en = !quiesce_q && state_q == hsdh_pkg::HSDH_NORMAL;
  assign tgt_disconnect = disc_q && txn_active;
  assign early_finish = quiesce_q && txn_active;
  // The three masks share one register so they always move together
  assign master_inhibit = quiesce_q;
  assign io_inhibit = quiesce_q;
  assign irq_inhibit = quiesce_q;
  assign hidden = hidden_q;
  assign quiesced = quiesce_q;

  // Checks run on the bus clock and sleep while the block is held in reset
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  hide_entry_a: assert property (
    (state_q == hsdh_pkg::HSDH_WAIT_RELEASE && rst_released && handle_unlocked && clk_en)
      |=> quiesced && !claim_en)
    else $error("hiding did not start after reset release with handle unlocked");

  early_finish_a: assert property (
    (state_q == hsdh_pkg::HSDH_PENDING && txn_active) |-> early_finish)
    else $error("transaction not cut short while hiding pending");

  quiesce_out_a: assert property (
    (state_q == hsdh_pkg::HSDH_PENDING || state_q == hsdh_pkg::HSDH_HIDDEN)
      |-> (master_inhibit && io_inhibit && irq_inhibit))
    else $error("master, io or interrupt not inhibited while quiesced");

  cfg_disconnect_a: assert property (
    (clk_en && state_q == hsdh_pkg::HSDH_PENDING && handle_unlocked && txn_active && txn_cfg)
      |=> (txn_active |-> tgt_disconnect))
    else $error("configuration transaction not disconnected on hiding");

  hidden_noclaim_a: assert property (
    hidden |-> (!claim_en && state_q == hsdh_pkg::HSDH_HIDDEN))
    else $error("target claim allowed while hidden");

  idle_hide_a: assert property (
    (clk_en && state_q == hsdh_pkg::HSDH_PENDING && !txn_active && handle_unlocked)
      |=> hidden ##0 !claim_en)
    else $error("idle bus did not hide at once");

  relock_cancel_a: assert property (
    (clk_en && hidden && !handle_unlocked) |=> (!hidden && !quiesced && claim_en))
    else $error("relock did not cancel hiding");

  boundary_flag_a: assert property (
    $rose(hidden) |-> !$past(txn_active))
    else $error("hidden flag set in mid transaction");

  wait_noclaim_a: assert property (
    state_q == hsdh_pkg::HSDH_WAIT_RELEASE |-> (!claim_en && !quiesced && !hidden))
    else $error("claim or quiesce seen before the hiding decision");

  locked_release_a: assert property (
    (clk_en && state_q == hsdh_pkg::HSDH_WAIT_RELEASE && rst_released && !handle_unlocked)
      |=> (claim_en && !quiesced))
    else $error("locked handle at reset release did not give normal operation");

  hold_quiesce_a: assert property (
    (clk_en && quiesced && handle_unlocked) |=> quiesced)
    else $error("quiesce dropped while handle still unlocked");

  hidden_hold_a: assert property (
    (clk_en && hidden && handle_unlocked) |=> hidden)
    else $error("hidden flag dropped while handle still unlocked");

  disc_scope_a: assert property (
    tgt_disconnect |-> (quiesced && !hidden && txn_active))
    else $error("disconnect signalled outside a pending transaction");

  pending_relock_a: assert property (
    (clk_en && state_q == hsdh_pkg::HSDH_PENDING && !handle_unlocked)
      |=> (claim_en && !quiesced && !tgt_disconnect))
    else $error("relock during pending did not cancel hiding");

  normal_release_a: assert property (
    (state_q == hsdh_pkg::HSDH_NORMAL)
      |-> (claim_en && !master_inhibit && !io_inhibit && !irq_inhibit))
    else $error("normal operation still restricted");

  state_freeze_a: assert property (
    !clk_en |=> ($stable(state_q) && $stable(hidden) && $stable(quiesced)))
    else $error("state moved while clock enable was low");
endmodule
`default_nettype wire

// [bench/hsdh_far_model.sv]
// Far-side model: handle switch, primary reset pin and bridge core status
`default_nettype none
module hsdh_far_model (
  // Levels seen by the block
  output logic primary_reset_in_n,
  output logic general_pin_three,
  output logic txn_active,
  output logic txn_cfg
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    primary_reset_in_n = 1'h0;
    general_pin_three = 1'h0;
    txn_active = 1'h0;
    txn_cfg = 1'h0;
  end
  // Handle level is already debounced, so it moves once and only at an edge
  task automatic set_levels(input logic rst_n, input logic unlocked, input logic act,
                            input logic cfg);
    primary_reset_in_n <= rst_n;
    general_pin_three <= unlocked;
    // No transaction is begun once the bridge is quiesced
    txn_active <= act;
    txn_cfg <= cfg;
  endtask
endmodule
`default_nettype wire

// [bench/hot_swap_device_hiding_control_tb_top.sv]
// Testbench: hiding entry, disconnect, idle hide, relock and clock-enable freeze
`default_nettype none
module hot_swap_device_hiding_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0;
  logic arst_n = 1'h0;
  logic clk_en = 1'h1;
  logic primary_reset_in_n, general_pin_three, txn_active, txn_cfg;
  logic claim_en, tgt_disconnect, early_finish, master_inhibit, io_inhibit, irq_inhibit;
  logic hidden, quiesced;
  logic [7:0] outs;
  int n_errors = 0;
  int cmp_count = 0;
  always #2 clk = ~clk;
  assign outs = {claim_en, tgt_disconnect, early_finish, master_inhibit, io_inhibit,
                 irq_inhibit, hidden, quiesced};
  hsdh_far_model u_far (.primary_reset_in_n(primary_reset_in_n),
    .general_pin_three(general_pin_three), .txn_active(txn_active), .txn_cfg(txn_cfg));
  hsdh_hide_ctrl u_dut (.clk(clk), .arst_n(arst_n), .clk_en(clk_en),
    .primary_reset_in_n(primary_reset_in_n), .general_pin_three(general_pin_three),
    .txn_active(txn_active), .txn_cfg(txn_cfg), .claim_en(claim_en),
    .tgt_disconnect(tgt_disconnect), .early_finish(early_finish),
    .master_inhibit(master_inhibit), .io_inhibit(io_inhibit), .irq_inhibit(irq_inhibit),
    .hidden(hidden), .quiesced(quiesced));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic step;
    @(posedge clk);
    #1;
  endtask
  // Bounded wait for the decision after reset release, or for claim after relock
  task automatic settle(input logic want_claim);
    int i;
    i = 0;
    do begin
      step();
      i++;
    end while (claim_en !== 1'h1 && (want_claim || quiesced !== 1'h1) && i < 8);
  endtask
  task automatic restart(input logic unlocked, input logic act, input logic cfg);
    @(posedge clk);
    arst_n <= 1'h0;
    u_far.set_levels(1'h0, unlocked, act, cfg);
    repeat (2) @(posedge clk);
    arst_n <= 1'h1;
    u_far.set_levels(1'h1, unlocked, act, cfg);
    settle(1'h0);
  endtask
  task automatic t_locked;
    restart(1'h0, 1'h0, 1'h0);
    check("locked_release", outs, 8'h80);
  endtask
  task automatic t_cfg_hide;
    restart(1'h1, 1'h1, 1'h1);
    check("cfg_pending", outs, 8'h7D);
    @(posedge clk);
    u_far.set_levels(1'h1, 1'h1, 1'h0, 1'h0);
    #1;
    check("cfg_done", outs, 8'h1D);
    step();
    check("cfg_hidden", outs, 8'h1F);
    repeat (6) step();
    check("hidden_hold", outs, 8'h1F);
    @(posedge clk);
    clk_en <= 1'h0;
    u_far.set_levels(1'h1, 1'h0, 1'h0, 1'h0);
    repeat (6) step();
    check("frozen", outs, 8'h1F);
    @(posedge clk);
    clk_en <= 1'h1;
    settle(1'h1);
    check("relock", outs, 8'h80);
  endtask
  task automatic t_idle_hide;
    restart(1'h1, 1'h0, 1'h0);
    check("idle_pending", outs, 8'h1D);
    step();
    check("idle_hidden", outs, 8'h1F);
  endtask
  task automatic t_mem_finish;
    restart(1'h1, 1'h1, 1'h0);
    check("mem_pending", outs, 8'h3D);
  endtask
  task automatic t_relock_pending;
    restart(1'h1, 1'h1, 1'h1);
    @(posedge clk);
    u_far.set_levels(1'h1, 1'h0, 1'h1, 1'h1);
    settle(1'h1);
    check("pending_relock", outs, 8'h80);
  endtask
  initial begin
    #2000;
    n_errors++;
    give_verdict();
  end
  initial begin
    t_locked();
    t_cfg_hide();
    t_idle_hide();
    t_mem_finish();
    t_relock_pending();
    give_verdict();
  end
endmodule
`default_nettype wire
